// >>> pkg/sfp_params.svh
/*
  Constants for the sector flash program controller: timing figures, their
  cycle counts at the system clock rate, and the command sequence words.
  Assumes a 40 MHz system clock and a byte-wide parallel flash on the pins.
*/
// Summary of operation
// - Sector address held on every load strobe.
// - Output enable high while writing.
// - Next load within byte load window.
// - Poll one unchanging address.
// - AA, 55, 90 then pause enters identification.
`ifndef SFP_PARAMS_SVH
`define SFP_PARAMS_SVH

`define SFP_ADDR_W      17
`define SFP_DATA_W      8
`define SFP_SECT_LSB    7
`define SFP_SECT_BYTES  128
`define SFP_TOGGLE_BIT  6
`define SFP_CLK_MHZ     40
`define SFP_T_WP_NS     90
`define SFP_T_WPH_NS    100
`define SFP_T_RD_NS     150
`define SFP_T_BLC_US    150
`define SFP_T_WC_MS     10
`define SFP_WP_CYC      ((`SFP_T_WP_NS * `SFP_CLK_MHZ + 999) / 1000)
`define SFP_WPH_CYC     ((`SFP_T_WPH_NS * `SFP_CLK_MHZ + 999) / 1000)
`define SFP_RD_CYC      ((`SFP_T_RD_NS * `SFP_CLK_MHZ + 999) / 1000)
`define SFP_BLC_CYC     (`SFP_T_BLC_US * `SFP_CLK_MHZ)
`define SFP_WC_CYC      (`SFP_T_WC_MS * `SFP_CLK_MHZ * 1000)
`define SFP_LOAD_GUARD  4
`define SFP_SEQ_ADDR_A  15'h5555
`define SFP_SEQ_ADDR_B  15'h2aaa
`define SFP_SEQ_DATA_A  8'haa
`define SFP_SEQ_DATA_B  8'h55
`define SFP_CMD_ID_IN   8'h90
`define SFP_CMD_ID_OUT  8'hf0
`define SFP_CMD_LOCK_LO 8'h40
`define SFP_CMD_LOCK_HI 8'h41

`endif

// >>> pkg/sfp_pkg.sv
/*
  Types shared by the sector flash program controller and its strobe engine.
  Assumes sfp_params.svh is on the include path.
*/
`include "sfp_params.svh"

package sfp_pkg;

  // Operations that the user side may request.
  typedef enum logic [2:0] {
    SFP_OP_READ, SFP_OP_LOAD, SFP_OP_ID_ENTER, SFP_OP_ID_EXIT,
    SFP_OP_LOCK_LO, SFP_OP_LOCK_HI
  } sfp_op_e;

  typedef struct packed {
    sfp_op_e                   op;
    logic [`SFP_ADDR_W-1:0]    addr;
    logic [`SFP_DATA_W-1:0]    data;
    logic                      last;
  } sfp_cmd_s;

  typedef struct packed {
    logic [`SFP_DATA_W-1:0]    data;
    logic                      timeout;
    logic                      partial;
  } sfp_rsp_s;

  // Flash pin group; strobes are active low, dq_oe high while driving.
  typedef struct packed {
    logic                      ce_n;
    logic                      oe_n;
    logic                      we_n;
    logic [`SFP_ADDR_W-1:0]    addr;
    logic [`SFP_DATA_W-1:0]    dq_out;
    logic                      dq_oe;
  } sfp_pins_s;

endpackage

// >>> src/sfp_strobe.sv
/*
  Single bus cycle engine: one write or one read on the flash pins per start.
  Assumes start is only raised while busy is low and dq_in is synchronous.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sfp_params.svh"

module sfp_strobe (
  input  wire logic                   clk_sys,
  input  wire logic                   reset,
  input  wire logic                   start,
  input  wire logic                   wr,
  input  wire logic [`SFP_ADDR_W-1:0] addr,
  input  wire logic [`SFP_DATA_W-1:0] data,
  input  wire logic [`SFP_DATA_W-1:0] dq_in,
  output sfp_pkg::sfp_pins_s          pins,
  output logic [`SFP_DATA_W-1:0]      rd_data,
  output logic                        done,
  output logic                        busy
);

  typedef enum logic [1:0] {SFS_IDLE, SFS_SETUP, SFS_PULSE, SFS_HOLD} sfp_st_e;

  sfp_st_e                 state;
  sfp_st_e                 next_state;
  logic [3:0]              cnt;
  logic [3:0]              next_cnt;
  logic                    is_wr;
  logic                    next_is_wr;
  sfp_pkg::sfp_pins_s      next_pins;
  logic [`SFP_DATA_W-1:0]  next_rd_data;
  logic                    next_done;

  assign busy = (state != SFS_IDLE);

  // Sequencer. Strobe high time covers both write-high and address hold.
  always_comb begin
    next_state   = state;
    next_cnt     = cnt;
    next_is_wr   = is_wr;
    next_pins    = pins;
    next_rd_data = rd_data;
    next_done    = 1'b0;
    unique case (state)
      SFS_IDLE: begin
        next_pins.dq_oe = 1'b0;
        if (start) begin
          next_state       = SFS_SETUP;
          next_is_wr       = wr;
          next_pins.addr   = addr;
          next_pins.dq_out = data;
          next_pins.dq_oe  = wr;
        end
      end
      SFS_SETUP: begin
        next_state     = SFS_PULSE;
        next_cnt       = 4'(`SFP_WP_CYC - 1);
        next_pins.ce_n = 1'b0;
        next_pins.we_n = ~is_wr;
        next_pins.oe_n = is_wr; // Never both write and output enable low.
        if (!is_wr) begin
          next_cnt = 4'(`SFP_RD_CYC - 1);
        end
      end
      SFS_PULSE: begin
        if (cnt == 4'h0) begin
          next_state     = SFS_HOLD;
          next_cnt       = 4'(`SFP_WPH_CYC - 1);
          next_pins.ce_n = 1'b1;
          next_pins.we_n = 1'b1;
          next_pins.oe_n = 1'b1; // Each read strobe ends here.
          if (!is_wr) begin
            next_rd_data = dq_in;
            next_cnt     = 4'(`SFP_RD_CYC - 1);
          end
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
      SFS_HOLD: begin
        if (cnt == 4'h0) begin
          next_state = SFS_IDLE;
          next_done  = 1'b1;
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
    endcase
  end

  // State registers.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state   <= SFS_IDLE;
      cnt     <= 4'h0;
      is_wr   <= 1'b0;
      pins    <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, default: '0};
      rd_data <= '0;
      done    <= 1'b0;
    end else begin
      state   <= next_state;
      cnt     <= next_cnt;
      is_wr   <= next_is_wr;
      pins    <= next_pins;
      rd_data <= next_rd_data;
      done    <= next_done;
    end
  end

endmodule
`default_nettype wire

// >>> src/sfp_host.sv
/*
  Host controller for a byte-wide sector flash: reads, sector byte loads with
  toggle polling, identification entry and exit, and boot block lockout.
  Assumes the user holds cmd stable while cmd_valid is high and not taken.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sfp_params.svh"

module sfp_host #(
  parameter logic [19:0] BLC_CYC  = 20'(`SFP_BLC_CYC),
  parameter logic [19:0] WC_CYC   = 20'(`SFP_WC_CYC),
  parameter logic [7:0]  CMD_EXIT = `SFP_CMD_ID_OUT,
  parameter logic [7:0]  CMD_LKLO = `SFP_CMD_LOCK_LO,
  parameter logic [7:0]  CMD_LKHI = `SFP_CMD_LOCK_HI
) (
  input  wire logic                   clk_sys,
  input  wire logic                   reset,
  input  wire logic                   cmd_valid,
  output logic                        cmd_ready,
  input  wire sfp_pkg::sfp_cmd_s      cmd,
  output logic                        rsp_valid,
  output sfp_pkg::sfp_rsp_s           rsp,
  output logic                        id_mode,
  output logic                        prog_busy,
  output sfp_pkg::sfp_pins_s          pins,
  input  wire logic [`SFP_DATA_W-1:0] dq_in
);

  localparam int SW = `SFP_ADDR_W - `SFP_SECT_LSB;

  typedef enum logic [2:0] {
    SFM_IDLE, SFM_READ, SFM_SEQ, SFM_PAUSE, SFM_LOAD_WR, SFM_LOAD_GAP, SFM_POLL
  } sfp_mst_e;

  sfp_mst_e                    state;
  sfp_mst_e                    next_state;
  sfp_pkg::sfp_cmd_s           cur;
  sfp_pkg::sfp_cmd_s           next_cur;
  logic [1:0]                  idx;
  logic [1:0]                  next_idx;
  logic [19:0]                 timer;
  logic [19:0]                 next_timer;
  logic [SW-1:0]               sector;
  logic [SW-1:0]               next_sector;
  logic [`SFP_SECT_BYTES-1:0]  mask;
  logic [`SFP_SECT_BYTES-1:0]  next_mask;
  logic                        prev_tog;
  logic                        next_prev_tog;
  logic                        have_prev;
  logic                        next_have_prev;
  logic                        next_id_mode;
  logic                        next_rsp_valid;
  sfp_pkg::sfp_rsp_s           next_rsp;
  logic                        b_start;
  logic                        next_b_start;
  logic                        b_wr;
  logic                        next_b_wr;
  logic [`SFP_ADDR_W-1:0]      b_addr;
  logic [`SFP_ADDR_W-1:0]      next_b_addr;
  logic [`SFP_DATA_W-1:0]      b_data;
  logic [`SFP_DATA_W-1:0]      next_b_data;
  logic [`SFP_DATA_W-1:0]      rd_data;
  logic                        b_done;
  logic                        b_busy;
  logic                        tog;
  logic                        gap_open;

  // Unlock sequence address for a step; upper address bits stay low.
  function automatic logic [`SFP_ADDR_W-1:0] seq_addr(input logic [1:0] i);
    seq_addr = {2'b00, (i == 2'd1) ? `SFP_SEQ_ADDR_B : `SFP_SEQ_ADDR_A};
  endfunction

  // Data for a step; the third word selects the operation.
  function automatic logic [7:0] seq_data(input logic [1:0] i, input sfp_pkg::sfp_op_e op);
    if (i == 2'd0) begin
      seq_data = `SFP_SEQ_DATA_A;
    end else if (i == 2'd1) begin
      seq_data = `SFP_SEQ_DATA_B;
    end else begin
      unique case (op)
        sfp_pkg::SFP_OP_ID_ENTER: seq_data = `SFP_CMD_ID_IN;
        sfp_pkg::SFP_OP_ID_EXIT:  seq_data = CMD_EXIT;
        sfp_pkg::SFP_OP_LOCK_LO:  seq_data = CMD_LKLO;
        default:                  seq_data = CMD_LKHI;
      endcase
    end
  endfunction

  sfp_strobe u_strobe (
    .clk_sys (clk_sys),
    .reset   (reset),
    .start   (b_start),
    .wr      (b_wr),
    .addr    (b_addr),
    .data    (b_data),
    .dq_in   (dq_in),
    .pins    (pins),
    .rd_data (rd_data),
    .done    (b_done),
    .busy    (b_busy)
  );

  assign tog       = rd_data[`SFP_TOGGLE_BIT];
  // A load taken this late could not strobe inside the window.
  assign gap_open  = (timer < BLC_CYC - 20'(`SFP_LOAD_GUARD));
  assign prog_busy = (state == SFM_POLL);

  // Only loads are taken between loads; nothing while programming runs.
  always_comb begin
    cmd_ready = 1'b0;
    if (state == SFM_IDLE && !b_busy && !b_start) begin
      cmd_ready = 1'b1;
    end else if (state == SFM_LOAD_GAP && gap_open) begin
      cmd_ready = (cmd.op == sfp_pkg::SFP_OP_LOAD);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequencer: picks bus cycles and tracks load and program phases.
  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_state     = state;
    next_cur       = cur;
    next_idx       = idx;
    next_timer     = timer + 20'h1;
    next_sector    = sector;
    next_mask      = mask;
    next_prev_tog  = prev_tog;
    next_have_prev = have_prev;
    next_id_mode   = id_mode;
    next_rsp_valid = 1'b0;
    next_rsp       = rsp;
    next_b_start   = 1'b0;
    next_b_wr      = b_wr;
    next_b_addr    = b_addr;
    next_b_data    = b_data;
    unique case (state)
      SFM_IDLE: begin
        next_timer = 20'h0;
        if (cmd_valid && cmd_ready) begin
          next_cur     = cmd;
          next_b_start = 1'b1;
          next_b_data  = cmd.data;
          unique case (cmd.op)
            sfp_pkg::SFP_OP_READ: begin
              next_state  = SFM_READ;
              next_b_wr   = 1'b0;
              next_b_addr = cmd.addr;
              if (id_mode) begin
                next_b_addr = {16'h0, cmd.addr[0]}; // Code select by bit 0.
              end
            end
            sfp_pkg::SFP_OP_LOAD: begin
              next_state  = SFM_LOAD_WR;
              next_b_wr   = 1'b1;
              next_b_addr = cmd.addr;
              next_sector = cmd.addr[`SFP_ADDR_W-1:`SFP_SECT_LSB]; // Latched sector.
              next_mask   = '0;
            end
            default: begin
              next_state  = SFM_SEQ;
              next_idx    = 2'd0;
              next_b_wr   = 1'b1;
              next_b_addr = seq_addr(2'd0);
              next_b_data = seq_data(2'd0, cmd.op);
            end
          endcase
        end
      end
      SFM_READ: begin
        if (b_done) begin
          next_state     = SFM_IDLE;
          next_rsp_valid = 1'b1;
          next_rsp       = '{data: rd_data, default: 1'b0};
        end
      end
      SFM_SEQ: begin
        next_timer = 20'h0;
        if (b_done) begin
          if (idx == 2'd2) begin
            next_state = SFM_PAUSE;
          end else begin
            next_idx     = idx + 2'd1;
            next_b_start = 1'b1;
            next_b_addr  = seq_addr(idx + 2'd1);
            next_b_data  = seq_data(idx + 2'd1, cur.op);
          end
        end
      end
      SFM_PAUSE: begin
        // The mode changes only after the full pause.
        if (timer == WC_CYC - 20'h1) begin
          next_state     = SFM_IDLE;
          next_rsp_valid = 1'b1;
          next_rsp       = '{default: '0};
          if (cur.op == sfp_pkg::SFP_OP_ID_ENTER) begin
            next_id_mode = 1'b1;
          end else if (cur.op == sfp_pkg::SFP_OP_ID_EXIT) begin
            next_id_mode = 1'b0; // Back to normal operation.
          end
        end
      end
      SFM_LOAD_WR: begin
        if (b_done) begin
          next_mask = mask | (`SFP_SECT_BYTES'(1) << b_addr[`SFP_SECT_LSB-1:0]);
          if (cur.last) begin
            next_state = SFM_LOAD_GAP;
            next_timer = BLC_CYC; // Close the window at once.
          end else begin
            next_state = SFM_LOAD_GAP;
          end
        end
      end
      SFM_LOAD_GAP: begin
        if (cmd_valid && cmd_ready) begin
          next_cur     = cmd;
          next_state   = SFM_LOAD_WR;
          next_timer   = 20'h0;
          next_b_start = 1'b1;
          next_b_data  = cmd.data;
          next_b_addr  = {sector, cmd.addr[`SFP_SECT_LSB-1:0]}; // Same sector.
        end else if (timer >= BLC_CYC) begin
          // Window has lapsed: the flash is now programming.
          next_state     = SFM_POLL;
          next_timer     = 20'h0;
          next_have_prev = 1'b0;
          next_b_start   = 1'b1;
          next_b_wr      = 1'b0;
          next_b_addr    = {sector, `SFP_SECT_LSB'(0)}; // Fixed poll address.
        end
      end
      SFM_POLL: begin
        if (b_done) begin
          // Done when two reads agree; no absolute level is trusted.
          if (have_prev && tog == prev_tog) begin
            next_state     = SFM_IDLE;
            next_rsp_valid = 1'b1;
            next_rsp       = '{data: rd_data, timeout: 1'b0, partial: ~&mask};
          end else if (timer >= WC_CYC) begin
            next_state     = SFM_IDLE;
            next_rsp_valid = 1'b1;
            next_rsp       = '{data: rd_data, timeout: 1'b1, partial: ~&mask};
          end else begin
            next_prev_tog  = tog;
            next_have_prev = 1'b1;
            next_b_start   = 1'b1; // New strobe, same address.
          end
        end
      end
    endcase
  end

  // Registers; reset stands for power-up, so identification mode clears.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state     <= SFM_IDLE;
      cur       <= '0;
      idx       <= 2'd0;
      timer     <= 20'h0;
      sector    <= '0;
      mask      <= '0;
      prev_tog  <= 1'b0;
      have_prev <= 1'b0;
      id_mode   <= 1'b0;
      rsp_valid <= 1'b0;
      rsp       <= '0;
      b_start   <= 1'b0;
      b_wr      <= 1'b0;
      b_addr    <= '0;
      b_data    <= '0;
    end else begin
      state     <= next_state;
      cur       <= next_cur;
      idx       <= next_idx;
      timer     <= next_timer;
      sector    <= next_sector;
      mask      <= next_mask;
      prev_tog  <= next_prev_tog;
      have_prev <= next_have_prev;
      id_mode   <= next_id_mode;
      rsp_valid <= next_rsp_valid;
      rsp       <= next_rsp;
      b_start   <= next_b_start;
      b_wr      <= next_b_wr;
      b_addr    <= next_b_addr;
      b_data    <= next_b_data;
    end
  end

endmodule
`default_nettype wire

// >>> verif/sfp_host_assertions.sv
/*
  Checker for the sector flash host: strobe shapes, polling and mode relations.
  Assumes it is bound to sfp_host and sees only that module's ports.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sfp_params.svh"

module sfp_host_assertions #(
  parameter logic [19:0] BLC_CYC = 20'd200,
  parameter logic [19:0] WC_CYC  = 20'd300
) (
  input wire logic                   clk_sys,
  input wire logic                   reset,
  input wire logic                   cmd_valid,
  input wire logic                   cmd_ready,
  input wire sfp_pkg::sfp_cmd_s      cmd,
  input wire logic                   rsp_valid,
  input wire sfp_pkg::sfp_rsp_s      rsp,
  input wire logic                   id_mode,
  input wire logic                   prog_busy,
  input wire sfp_pkg::sfp_pins_s     pins,
  input wire logic [`SFP_DATA_W-1:0] dq_in
);
  // Polling may run to the timeout, plus one read and the reply.
  localparam int POLL_MAX = WC_CYC + 64;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  ////////////////////////////////////////////////////////////////////////////
  // Strobe shapes on the flash pins.
  property p_oe_write; (!pins.we_n && !pins.ce_n) |-> pins.oe_n; endproperty
  a_oe_write: assert property (p_oe_write)
    else $error("output enable low during a write strobe");
  // Both sides driving the data bus at once would fight on the board.
  property p_no_fight; !pins.oe_n |-> !pins.dq_oe; endproperty
  a_no_fight: assert property (p_no_fight)
    else $error("host drives data while output enable is low");
  property p_wr_pulse;
    $fell(pins.we_n) |-> (!pins.we_n && !pins.ce_n && $stable(pins.addr))[*4] ##1 pins.we_n;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse)
    else $error("write pulse shape or address hold wrong");
  property p_wr_high; $rose(pins.we_n) |-> pins.we_n[*4]; endproperty
  a_wr_high: assert property (p_wr_high)
    else $error("write strobe high time too short");

  ////////////////////////////////////////////////////////////////////////////
  // Polling behaviour.
  property p_poll_addr;
    $fell(pins.oe_n) && prog_busy |-> (pins.addr[6:0] == 7'h00) ##1 $stable(pins.addr)[*5];
  endproperty
  a_poll_addr: assert property (p_poll_addr)
    else $error("poll read address not fixed");
  property p_poll_bound; $rose(prog_busy) |-> ##[1:POLL_MAX] !prog_busy; endproperty
  a_poll_bound: assert property (p_poll_bound)
    else $error("polling did not end in time");
  property p_busy_refuse; prog_busy |-> !cmd_ready; endproperty
  a_busy_refuse: assert property (p_busy_refuse)
    else $error("request accepted while polling");

  ////////////////////////////////////////////////////////////////////////////
  // Identification mode.
  property p_id_read; id_mode && $fell(pins.oe_n) |-> pins.addr[16:1] == 16'h0000; endproperty
  a_id_read: assert property (p_id_read)
    else $error("identification read address has high bits set");
  property p_id_reset; $fell(reset) |-> !id_mode; endproperty
  a_id_reset: assert property (p_id_reset)
    else $error("identification mode survived reset");
endmodule
`default_nettype wire

// >>> verif/sfp_flash_model.sv
/*
  Behavioural byte-wide sector flash: loads, timed program, toggle bit, modes.
  Assumes pins from sfp_host; prog_cyc sets the program time in clocks.
*/
`timescale 1ns/1ps
`default_nettype none

module sfp_flash_model #(
  parameter logic [7:0] MAKER = 8'h3c, // Arbitrary value.
  parameter logic [7:0] PART  = 8'hc3, // Arbitrary value.
  parameter int         BLC   = 200
) (
  input  wire logic               clk_sys,
  input  wire logic               reset,
  input  wire sfp_pkg::sfp_pins_s pins,
  input  wire logic [19:0]        prog_cyc,
  output logic [7:0]              dq_in
);
  logic [7:0] mem [int];
  logic [7:0] ld [int];
  logic [9:0] sect;
  logic [7:0] pend;
  logic       loading, idm, lk_lo, lk_hi, tog, prev_we, prev_rd, rd;
  int         busy, gap, seq;

  // Start values; the toggle bit begins at one.
  initial begin
    dq_in = 8'h00; loading = 0; idm = 0; lk_lo = 0; lk_hi = 0;
    tog = 1; prev_we = 1; prev_rd = 0; busy = 0; gap = 0; seq = 0; pend = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timed internal cycle; pend 00 means a sector program.
  task automatic start_prog(input logic [7:0] what);
    loading = 1'b0; pend = what; busy = int'(prog_cyc);
  endtask

  task automatic finish;
    if (pend == 8'h90) idm = 1'b1;
    else if (pend == 8'hf0) idm = 1'b0;
    else if (pend == 8'h40) lk_lo = 1'b1;
    else if (pend == 8'h41) lk_hi = 1'b1;
    else if (!(lk_lo && sect < 10'd64) && !(lk_hi && sect >= 10'd960))
      for (int i = 0; i < 128; i++)
        mem[int'({sect, 7'(i)})] = ld.exists(i) ? ld[i] : 8'(i) ^ 8'ha5;
  endtask

  // Writes are split into command steps and sector loads.
  task automatic write_event;
    logic [14:0] a;
    a = pins.addr[14:0];
    if (seq == 0 && a == 15'h5555 && pins.dq_out == 8'haa) seq = 1;
    else if (seq == 1 && a == 15'h2aaa && pins.dq_out == 8'h55) seq = 2;
    else if (seq == 2 && a == 15'h5555) begin
      seq = 0;
      start_prog(pins.dq_out);
    end else begin
      seq = 0;
      if (!loading) begin
        loading = 1'b1;
        sect = pins.addr[16:7];
        ld.delete();
      end
      ld[int'(pins.addr[6:0])] = pins.dq_out;
      gap = 0;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Pin watcher; reset stands for a power loss.
  always @(posedge clk_sys) begin
    rd = !pins.oe_n && !pins.ce_n;
    if (reset) begin
      idm = 1'b0; seq = 0; busy = 0; loading = 1'b0;
    end else begin
      if (busy > 0) begin
        busy--;
        if (busy == 0) finish();
      end
      if (loading && ++gap > BLC) start_prog(8'h00);
      if (rd && !prev_rd) begin
        if (loading) start_prog(8'h00);
        if (busy > 0) tog = ~tog;
      end
      // An undriven data bus carries nothing, so a write without dq_oe is lost.
      if (prev_we && !pins.we_n && !pins.ce_n && pins.dq_oe && busy == 0) write_event();
    end
    // A released bus shows a changing pattern, never a held value.
    if (!rd) dq_in <= ~dq_in;
    else if (busy > 0) dq_in <= {1'b0, tog, 6'h00};
    else if (idm && pins.addr[16:1] == 16'h0000) dq_in <= pins.addr[0] ? PART : MAKER;
    else dq_in <= mem.exists(int'(pins.addr)) ? mem[int'(pins.addr)] : 8'hff;
    prev_rd = rd;
    prev_we = pins.we_n;
  end
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
/*
  Self-checking bench for sfp_host against the behavioural flash model.
  Assumes short counts: byte window 200 clocks, program timeout 300 clocks.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  localparam logic [7:0] MAKER_CODE = 8'h3c; // Arbitrary value.
  localparam logic [7:0] PART_CODE  = 8'hc3; // Arbitrary value.
  logic               clk_sys = 1'b0;
  logic               reset = 1'b1;
  logic               cmd_valid = 1'b0;
  sfp_pkg::sfp_cmd_s  cmd = '0;
  logic               cmd_ready, rsp_valid, id_mode, prog_busy;
  sfp_pkg::sfp_rsp_s  rsp;
  sfp_pkg::sfp_pins_s pins;
  logic [7:0]         dq_in;
  logic [19:0]        prog_cyc = 20'd40;
  logic               flash_idle;
  int                 fail_count = 0;
  int                 checks = 0;

  always #12.5 clk_sys = ~clk_sys;

  sfp_host #(.BLC_CYC(20'd200), .WC_CYC(20'd300)) uut (.clk_sys(clk_sys), .reset(reset),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd), .rsp_valid(rsp_valid),
    .rsp(rsp), .id_mode(id_mode), .prog_busy(prog_busy), .pins(pins), .dq_in(dq_in));
  sfp_flash_model #(.MAKER(MAKER_CODE), .PART(PART_CODE), .BLC(200)) flash (
    .clk_sys(clk_sys), .reset(reset), .pins(pins), .prog_cyc(prog_cyc), .dq_in(dq_in));

  // Model idle flag, so that the wait for a slow program is bounded like every other wait.
  assign flash_idle = (flash.busy == 0);

  ////////////////////////////////////////////////////////////////////////////
  // Reporting and comparison.
  task automatic conclude;
    $display("counts: checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmp1(input string what, input logic exp, input logic got);
    cmp8(what, {7'h00, exp}, {7'h00, got});
  endtask

  // Bounded wait on a signal sampled at the falling edge.
  task automatic wait_for(input string what, ref logic sig, input int lim);
    int n;
    n = 0;
    while (sig !== 1'b1) begin
      @(negedge clk_sys);
      if (++n > lim) begin
        fail_count++;
        $display("[ERR] %s expected 1 seen timeout", what);
        conclude();
      end
    end
  endtask

  // One request; held until taken, then optionally wait for the reply.
  task automatic issue(input sfp_pkg::sfp_op_e op, input logic [16:0] a, input logic [7:0] d,
                       input logic last, input logic want);
    @(negedge clk_sys);
    cmd_valid = 1'b1;
    cmd = '{op: op, addr: a, data: d, last: last};
    #1;
    wait_for("cmd_ready", cmd_ready, 4000);
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    if (want) wait_for("rsp_valid", rsp_valid, 4000);
  endtask

  task automatic rd_chk(input logic [16:0] a, input logic [7:0] exp);
    issue(sfp_pkg::SFP_OP_READ, a, 8'h00, 1'b0, 1'b1);
    cmp8("read data", exp, rsp.data);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic t_full_sector;
    for (int i = 0; i < 128; i++)
      issue(sfp_pkg::SFP_OP_LOAD, {10'd5, 7'(i)}, 8'(i) + 8'h10, 1'(i == 127), 1'(i == 127));
    cmp1("timeout", 1'b0, rsp.timeout);
    cmp1("partial", 1'b0, rsp.partial);
    rd_chk({10'd5, 7'd0}, 8'h10);
    rd_chk({10'd5, 7'd127}, 8'h8f);
    $display("test done: full sector");
  endtask

  task automatic t_window;
    issue(sfp_pkg::SFP_OP_LOAD, {10'd6, 7'd3}, 8'h61, 1'b0, 1'b0);
    // The second load names another sector; the controller must keep the first one.
    issue(sfp_pkg::SFP_OP_LOAD, {10'd9, 7'd4}, 8'h62, 1'b0, 1'b1);
    cmp1("partial", 1'b1, rsp.partial);
    cmp1("timeout", 1'b0, rsp.timeout);
    rd_chk({10'd6, 7'd3}, 8'h61);
    rd_chk({10'd6, 7'd4}, 8'h62);
    $display("test done: load window");
  endtask

  task automatic t_slow;
    prog_cyc = 20'd600;
    issue(sfp_pkg::SFP_OP_LOAD, {10'd7, 7'd0}, 8'h70, 1'b1, 1'b1);
    cmp1("timeout", 1'b1, rsp.timeout);
    wait_for("flash idle", flash_idle, 1000);
    prog_cyc = 20'd40;
    $display("test done: slow program");
  endtask

  task automatic t_ident;
    issue(sfp_pkg::SFP_OP_ID_ENTER, 17'h00000, 8'h00, 1'b0, 1'b1);
    cmp1("id_mode", 1'b1, id_mode);
    rd_chk(17'h00000, MAKER_CODE);
    rd_chk(17'h00001, PART_CODE);
    issue(sfp_pkg::SFP_OP_ID_EXIT, 17'h00000, 8'h00, 1'b0, 1'b1);
    cmp1("id_mode", 1'b0, id_mode);
    rd_chk({10'd5, 7'd0}, 8'h10);
    $display("test done: identification");
  endtask

  task automatic t_lockout;
    issue(sfp_pkg::SFP_OP_LOCK_LO, 17'h00000, 8'h00, 1'b0, 1'b1);
    issue(sfp_pkg::SFP_OP_LOAD, {10'd0, 7'd9}, 8'h77, 1'b1, 1'b1);
    rd_chk({10'd0, 7'd9}, 8'hff);
    issue(sfp_pkg::SFP_OP_LOAD, {10'd1023, 7'd9}, 8'h78, 1'b1, 1'b1);
    rd_chk({10'd1023, 7'd9}, 8'h78);
    issue(sfp_pkg::SFP_OP_LOCK_HI, 17'h00000, 8'h00, 1'b0, 1'b1);
    issue(sfp_pkg::SFP_OP_LOAD, {10'd1023, 7'd9}, 8'h79, 1'b1, 1'b1);
    rd_chk({10'd1023, 7'd9}, 8'h78);
    $display("test done: boot lockout");
  endtask

  task automatic t_reset_id;
    issue(sfp_pkg::SFP_OP_ID_ENTER, 17'h00000, 8'h00, 1'b0, 1'b1);
    @(negedge clk_sys);
    reset = 1'b1;
    repeat (16) @(negedge clk_sys);
    reset = 1'b0;
    cmp1("id_mode", 1'b0, id_mode);
    rd_chk(17'h00000, 8'hff);
    $display("test done: reset leaves identification");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    repeat (16) @(negedge clk_sys);
    reset = 1'b0;
    t_full_sector();
    t_window();
    t_slow();
    t_ident();
    t_lockout();
    t_reset_id();
    conclude();
  end
endmodule

bind sfp_host sfp_host_assertions #(.BLC_CYC(BLC_CYC), .WC_CYC(WC_CYC)) chk (
  .clk_sys(clk_sys), .reset(reset), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
  .cmd(cmd), .rsp_valid(rsp_valid), .rsp(rsp), .id_mode(id_mode),
  .prog_busy(prog_busy), .pins(pins), .dq_in(dq_in));
`default_nettype wire
